// File: obi_interlock.sv
// Purpose: Sampled interlock between a motor converter and its output breaker.
// Assumes: Breaker and DC-link pins are asynchronous; converter signals are
//          on clk_sys. APB slave with zero wait states.
// Notes:   All logic blocks advance only on the common sampling tick.
//          Events latch in ISTAT; software clears them by writing ones.
//
// Overview of operation
// - Breaker-release output 0 carries the inverted converter fault status.
// - On-delay asserts only after contactor request stays high 4000 ms.
// - Feedback pulse generator starts from on-delay output, 5000 ms pulse.
// - OR feedback pulse with breaker-closed input; spare OR inputs are zero.
// - AND the OR result with contactor request; spare AND inputs are one.
// - AND result is the line-contactor feedback to the converter.
// - Operation enable comes straight from the breaker-closed input.
// - Flag a fault if feedback fails to follow request within 5000 ms.
// - Inverter pulses are enabled only while the breaker reports closed.
// - Close-command pulse generator starts from operation control, 5000 ms.
// - Close-command pulse drives breaker-close output 1.
// - Switch-on is permitted only while DC link voltage is present.
// - All blocks update together on one common sampling tick.
// - Sampling period is three base sampling units.
`timescale 1ns/1ps
module obi_interlock #(
  parameter int unsigned TICK_CYCLES = obi_pkg::TICK_CYCLES,
  parameter int unsigned ON_DELAY_TICKS = obi_pkg::ON_DELAY_TICKS,
  parameter int unsigned FB_PULSE_TICKS = obi_pkg::FB_PULSE_TICKS,
  parameter int unsigned CLOSE_PULSE_TICKS = obi_pkg::CLOSE_PULSE_TICKS,
  parameter int unsigned MON_TICKS = obi_pkg::MON_TICKS
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire obi_pkg::obi_conv_s conv,
  input wire logic breaker_closed_input,
  input wire logic dc_link_present,
  output obi_pkg::obi_drv_s drv,
  output logic irq
);
  import obi_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: first stage feeds only the second
  // Both reset to the open and absent levels, so no false edge follows
  logic [1:0] brk_meta_q, brk_meta_d;
  logic brk_s;
  always_comb begin
    brk_meta_d = {brk_meta_q[0], breaker_closed_input};
  end
  logic [1:0] dc_meta_q, dc_meta_d;
  logic dc_s;
  always_comb begin
    dc_meta_d = {dc_meta_q[0], dc_link_present};
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      brk_meta_q <= 2'h0;
      dc_meta_q <= 2'h0;
    end else begin
      brk_meta_q <= brk_meta_d;
      dc_meta_q <= dc_meta_d;
    end
  end
  assign brk_s = brk_meta_q[1];
  assign dc_s = dc_meta_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Sampling tick: one period is three base units of the block group
  // A wide counter costs a few flops but fits any sampling period
  logic [31:0] tick_cnt_q, tick_cnt_d;
  logic tick;
  always_comb begin
    tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));
    tick_cnt_d = tick ? 32'h0 : tick_cnt_q + 32'h1;
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_q <= 32'h0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file state
  logic [1:0] ctrl_q, ctrl_d;
  logic [NUM_EV-1:0] istat_q, istat_d, imask_q, imask_d;
  logic [NUM_EV-1:0] ev;
  logic wr_en, rd_en, mapped;
  always_comb begin
    wr_en = psel && penable && pwrite;
    rd_en = psel && penable && !pwrite;
    mapped = (paddr == CTRL_OFS) || (paddr == STATUS_OFS) ||
             (paddr == ISTAT_OFS) || (paddr == IMASK_OFS);
  end

  ////////////////////////////////////////////////////////////////////////////
  // On-delay on the contactor request
  // Sampled only on the tick; a dip between two ticks goes unseen
  // Counting stops once the output is set, so the counter cannot wrap
  logic [15:0] od_cnt_q, od_cnt_d;
  logic od_q, od_d;
  always_comb begin
    od_cnt_d = od_cnt_q;
    od_d = od_q;
    if (tick) begin
      if (!conv.contactor_ctrl) begin
        od_cnt_d = 16'h0;
        od_d = 1'b0;
      end else if (!od_q) begin
        if (od_cnt_q == 16'(ON_DELAY_TICKS - 1)) begin
          od_d = 1'b1;
        end else begin
          od_cnt_d = od_cnt_q + 16'h1;
        end
      end
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      od_cnt_q <= 16'h0;
      od_q <= 1'b0;
    end else begin
      od_cnt_q <= od_cnt_d;
      od_q <= od_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse generators: 0 is the close command, 1 the feedback substitute
  // Edge memory follows the input every tick, so a held level fires once
  logic [1:0] pg_in;
  logic [1:0] pg_run_q, pg_run_d, pg_prev_q, pg_prev_d;
  logic [15:0] pg_cnt_q [2];
  logic [15:0] pg_cnt_d [2];
  logic [15:0] pg_len [2];
  assign pg_in[0] = conv.operation_ctrl;
  assign pg_in[1] = od_q;
  assign pg_len[0] = 16'(CLOSE_PULSE_TICKS);
  assign pg_len[1] = 16'(FB_PULSE_TICKS);

  for (genvar g = 0; g < 2; g++) begin : g_pg
    always_comb begin
      pg_run_d[g] = pg_run_q[g];
      pg_cnt_d[g] = pg_cnt_q[g];
      pg_prev_d[g] = pg_prev_q[g];
      if (tick) begin
        pg_prev_d[g] = pg_in[g];
        if (pg_run_q[g]) begin
          // Retriggers while running are ignored
          if (pg_cnt_q[g] == pg_len[g] - 16'h1) begin
            pg_run_d[g] = 1'b0;
          end else begin
            pg_cnt_d[g] = pg_cnt_q[g] + 16'h1;
          end
        end else if (pg_in[g] && !pg_prev_q[g]) begin
          pg_run_d[g] = 1'b1;
          pg_cnt_d[g] = 16'h0;
        end
      end
    end
    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        pg_run_q[g] <= 1'b0;
        pg_prev_q[g] <= 1'b0;
        pg_cnt_q[g] <= 16'h0;
      end else begin
        pg_run_q[g] <= pg_run_d[g];
        pg_prev_q[g] <= pg_prev_d[g];
        pg_cnt_q[g] <= pg_cnt_d[g];
      end
    end
    // Explicit clock: these sit ahead of the module's default clocking
    chk_pulse_length: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      $fell(pg_run_q[g]) |-> $past(pg_cnt_q[g]) == pg_len[g] - 16'h1)
      else $error("pulse ended at the wrong length");
    // A pulse may only start from a fresh edge seen on a tick
    chk_pulse_start: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      $rose(pg_run_q[g]) |-> $past(tick && pg_in[g] && !pg_prev_q[g]))
      else $error("pulse started without a rising edge");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output logic, all updated on the tick
  // Spare gate inputs stay literal so the tie-offs remain visible
  logic or_res, and_res;
  obi_drv_s drv_q, drv_d;
  logic [15:0] mon_cnt_q, mon_cnt_d;
  always_comb begin
    or_res = pg_run_q[1] | brk_s | 1'b0 | 1'b0;
    and_res = or_res & conv.contactor_ctrl & 1'b1 & 1'b1;
    drv_d = drv_q;
    mon_cnt_d = mon_cnt_q;
    if (tick) begin
      drv_d.breaker_release_do0 = !conv.fault_active;
      drv_d.breaker_close_do1 = pg_run_q[0] &&
                                ctrl_q[CTRL_CLOSE_EN_BIT];
      drv_d.line_contactor_fb = and_res;
      drv_d.operation_enable = brk_s;
      drv_d.pulse_enable = brk_s;
      drv_d.switch_on_permit = conv.on_request && dc_s;
      // Supervise feedback against request; cleared once they agree
      // Either direction counts, but feedback is ANDed with the request, so a stuck-closed contact does not show
      if (!ctrl_q[CTRL_MON_EN_BIT] ||
          (conv.contactor_ctrl == drv_q.line_contactor_fb)) begin
        mon_cnt_d = 16'h0;
        drv_d.contactor_fault = 1'b0;
      end else if (!drv_q.contactor_fault) begin
        if (mon_cnt_q == 16'(MON_TICKS - 1)) begin
          drv_d.contactor_fault = 1'b1;
        end else begin
          mon_cnt_d = mon_cnt_q + 16'h1;
        end
      end
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      drv_q <= '0;
      mon_cnt_q <= 16'h0;
    end else begin
      drv_q <= drv_d;
      mon_cnt_q <= mon_cnt_d;
    end
  end
  assign drv = drv_q;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and interrupt; a new event wins over a same-cycle clear
  // Close enable lets software keep the breaker open while commissioning
  logic brk_prev_q, brk_prev_d;
  always_comb begin
    brk_prev_d = brk_s;
    ev = '0;
    ev[EV_MON_FAULT] = drv_d.contactor_fault && !drv_q.contactor_fault;
    ev[EV_TRIP] = !drv_d.breaker_release_do0 && drv_q.breaker_release_do0;
    ev[EV_BRK_OPEN] = brk_prev_q && !brk_s;
    ctrl_d = ctrl_q;
    imask_d = imask_q;
    istat_d = istat_q;
    if (wr_en && paddr == CTRL_OFS) begin
      ctrl_d = pwdata[1:0];
    end
    if (wr_en && paddr == IMASK_OFS) begin
      imask_d = pwdata[NUM_EV-1:0];
    end
    if (wr_en && paddr == ISTAT_OFS) begin
      istat_d = istat_q & ~pwdata[NUM_EV-1:0];
    end
    istat_d = istat_d | ev;
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RESET;
      imask_q <= '0;
      istat_q <= '0;
      brk_prev_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      imask_q <= imask_d;
      istat_q <= istat_d;
      brk_prev_q <= brk_prev_d;
    end
  end
  assign irq = |(istat_q & imask_q);

  // Read mux; zero wait states, unmapped addresses answer with an error
  // Status shows live levels only; nothing clears on a read
  logic [STATUS_W-1:0] status;
  always_comb begin
    status = {od_q, pg_run_q, drv_q.contactor_fault, drv_q.line_contactor_fb,
              drv_q.switch_on_permit, dc_s, brk_s,
              !drv_q.breaker_release_do0};
    prdata = 32'h0;
    if (rd_en) begin
      unique case (paddr)
        CTRL_OFS: prdata = {30'h0, ctrl_q};
        STATUS_OFS: prdata = {23'h0, status};
        ISTAT_OFS: prdata = {29'h0, istat_q};
        IMASK_OFS: prdata = {29'h0, imask_q};
        default: prdata = 32'h0;
      endcase
    end
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // One clock domain, so a single default clocking serves the rest
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  chk_release_inverts: assert property (
    tick |=> drv.breaker_release_do0 == !$past(conv.fault_active))
    else $error("release output not the inverted fault");
  chk_ondelay_time: assert property (
    $rose(od_q) |-> $past(od_cnt_q) == 16'(ON_DELAY_TICKS - 1))
    else $error("on-delay fired early or late");
  chk_ondelay_clear: assert property (
    tick && !conv.contactor_ctrl |=> !od_q && od_cnt_q == 16'h0)
    else $error("on-delay not cleared on input drop");
  chk_feedback_and: assert property (
    tick |=> drv.line_contactor_fb ==
      ($past(pg_run_q[1] | brk_s) && $past(conv.contactor_ctrl)))
    else $error("contactor feedback logic mismatch");
  chk_operation_from_brk: assert property (
    tick |=> drv.operation_enable == $past(brk_s) &&
      drv.pulse_enable == drv.operation_enable)
    else $error("operation or pulse enable not from breaker");
  chk_monitor_time: assert property (
    $rose(drv.contactor_fault) |-> $past(mon_cnt_q) == 16'(MON_TICKS - 1))
    else $error("contactor supervision timed wrongly");
  // Close output follows the pulse and the enable sampled on the tick
  chk_close_output: assert property (
    tick |=> drv.breaker_close_do1 ==
      ($past(pg_run_q[0]) && $past(ctrl_q[CTRL_CLOSE_EN_BIT])))
    else $error("close output not the gated close pulse");
  chk_dc_permit: assert property (
    $rose(drv.switch_on_permit) |-> $past(dc_s) && $past(conv.on_request))
    else $error("switch-on permitted without DC link");
  chk_blocks_on_tick: assert property (
    !$past(tick) |-> $stable(drv) && $stable(od_q) && $stable(pg_run_q))
    else $error("block output changed off the tick");
  // The interrupt may only rise on a new event or a mask write
  chk_irq_level: assert property (
    $rose(irq) |-> $past(|ev) || $past(wr_en && paddr == IMASK_OFS))
    else $error("interrupt rose without cause");
  // An event must stick even when a clear lands in the same cycle
  chk_event_sticky: assert property (
    (|ev) |=> (istat_q & $past(ev)) == $past(ev))
    else $error("event lost against a clear");
  // Writes to unmapped addresses must leave CTRL and IMASK alone
  chk_unmapped_write: assert property (
    wr_en && !mapped |=> $stable(ctrl_q) && $stable(imask_q))
    else $error("unmapped write changed a register");

endmodule : obi_interlock

// File: obi_pkg.sv
// Purpose: Shared constants and carriers for the output breaker interlock.
// Assumes: 200 MHz system clock; one sampling tick drives all logic blocks.
// Notes:   Times are kept in their own unit; tick counts derive from them.
package obi_pkg;

  // Clock and sampling tick
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned BASE_UNIT_US = 1000;
  localparam int unsigned GROUP0_FACTOR = 3;
  localparam int unsigned TICK_US = BASE_UNIT_US * GROUP0_FACTOR;
  localparam int unsigned TICK_CYCLES = TICK_US * CLK_PER_US;

  // Block times in ms; least times round up to whole ticks
  localparam int unsigned ON_DELAY_MS = 4000;
  localparam int unsigned FB_PULSE_MS = 5000;
  localparam int unsigned CLOSE_PULSE_MS = 5000;
  localparam int unsigned MON_TIME_MS = 5000;
  localparam int unsigned ON_DELAY_TICKS =
    (ON_DELAY_MS * 1000 + TICK_US - 1) / TICK_US;
  localparam int unsigned FB_PULSE_TICKS =
    (FB_PULSE_MS * 1000 + TICK_US - 1) / TICK_US;
  localparam int unsigned CLOSE_PULSE_TICKS =
    (CLOSE_PULSE_MS * 1000 + TICK_US - 1) / TICK_US;
  localparam int unsigned MON_TICKS =
    (MON_TIME_MS * 1000 + TICK_US - 1) / TICK_US;

  // Register map (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] ISTAT_OFS = 8'h08;
  localparam logic [7:0] IMASK_OFS = 8'h0c;

  // Control fields
  localparam int CTRL_MON_EN_BIT = 0;
  localparam int CTRL_CLOSE_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;

  // Interrupt events
  localparam int EV_MON_FAULT = 0;
  localparam int EV_TRIP = 1;
  localparam int EV_BRK_OPEN = 2;
  localparam int NUM_EV = 3;

  // Status fields (STATUS register bits 0..8)
  localparam int STATUS_W = 9;

  // Requests from the converter control, same clock domain
  typedef struct packed {
    logic fault_active;
    logic contactor_ctrl;
    logic operation_ctrl;
    logic on_request;
  } obi_conv_s;

  // Results back to the converter and to the breaker outputs
  typedef struct packed {
    logic breaker_release_do0;
    logic breaker_close_do1;
    logic line_contactor_fb;
    logic operation_enable;
    logic pulse_enable;
    logic switch_on_permit;
    logic contactor_fault;
  } obi_drv_s;

endpackage : obi_pkg

// File: obi_breaker_model.sv
// Purpose: Behavioural output-side breaker with its auxiliary contact.
// Assumes: Closes on a close command only while release is held high.
// Notes:   Contact answers RESP_CYCLES late to mimic slow mechanics.
`timescale 1ns/1ps
module obi_breaker_model #(
  parameter int RESP_CYCLES = 3
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic release_ok,
  input wire logic close_cmd,
  output logic closed
);
  logic want_q;
  int cnt_q;

  // Trip wins over close, as a shunt release would
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      want_q <= 1'b0;
      cnt_q <= 0;
      closed <= 1'b0;
    end else begin
      if (!release_ok) begin
        want_q <= 1'b0;
      end else if (close_cmd) begin
        want_q <= 1'b1;
      end
      if (closed != want_q) begin
        cnt_q <= cnt_q + 1;
        if (cnt_q >= RESP_CYCLES - 1) begin
          closed <= want_q;
          cnt_q <= 0;
        end
      end else begin
        cnt_q <= 0;
      end
    end
  end
endmodule : obi_breaker_model

// File: tb.sv
// Purpose: Self-checking bench for the output breaker interlock.
// Assumes: Short tick and block counts so the run stays brief.
// Notes:   Outputs are sampled on the falling edge, when settled.
`timescale 1ns/1ps
module tb;
  import obi_pkg::*;
  localparam int TC = 4;
  localparam int OND = 3;
  localparam int FBP = 4;
  localparam int CLP = 4;
  localparam int MON = 6;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  obi_conv_s conv_r = '0;
  logic brk;
  logic dc = 1'b0;
  obi_drv_s drv;
  logic irq;
  logic [31:0] rv;
  logic er;
  int fails = 0;
  int total_checks = 0;
  int n;

  always #2.5 clk_sys = ~clk_sys;

  obi_interlock #(.TICK_CYCLES(TC), .ON_DELAY_TICKS(OND),
    .FB_PULSE_TICKS(FBP), .CLOSE_PULSE_TICKS(CLP), .MON_TICKS(MON)) dut_u (
    .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv(conv_r),
    .breaker_closed_input(brk), .dc_link_present(dc), .drv(drv), .irq(irq));

  // Slow breaker so the feedback path sees real mechanical lag
  obi_breaker_model #(.RESP_CYCLES(3)) brk_u (.clk_sys(clk_sys),
    .nrst(nrst), .release_ok(drv.breaker_release_do0),
    .close_cmd(drv.breaker_close_do1), .closed(brk));

  ////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  task chk(input logic [32:0] got, input logic [32:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Waits are bounded; a hang ends the run as a mismatch
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      fails++;
      report_and_stop;
    end
  endtask : apb

  task wait_bit(input int b, input logic v, input int mx, output int k);
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (drv[b] !== v && k < mx);
    if (drv[b] !== v) begin
      fails++;
      report_and_stop;
    end
  endtask : wait_bit

  task high_len(input int b, output int k);
    k = 0;
    while (drv[b] === 1'b1 && k < 400) begin
      @(negedge clk_sys);
      k++;
    end
  endtask : high_len

  task ticks(input int t);
    repeat (t * TC) @(posedge clk_sys);
  endtask : ticks

  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    apb(1'b0, CTRL_OFS, 0);
    chk(rv, 32'h3);
    apb(1'b0, IMASK_OFS, 0);
    chk(rv, 32'h0);
    apb(1'b0, ISTAT_OFS, 0);
    chk(rv, 32'h0);
    apb(1'b1, 8'h10, 32'hffff_ffff);
    chk(er, 1'b1);
    apb(1'b0, 8'h10, 0);
    chk({er, rv}, {1'b1, 32'h0});
    $display("test regs done");
  endtask : t_regs

  task t_permit;
    @(posedge clk_sys);
    conv_r.on_request <= 1'b1;
    ticks(4);
    chk(drv.switch_on_permit, 1'b0);
    dc <= 1'b1;
    wait_bit(1, 1'b1, 4 * TC, n);
    @(posedge clk_sys);
    dc <= 1'b0;
    wait_bit(1, 1'b0, 4 * TC, n);
    $display("test permit done");
  endtask : t_permit

  // Retrigger inside the close pulse must not stretch it
  task t_close_trip;
    @(posedge clk_sys);
    conv_r.operation_ctrl <= 1'b1;
    wait_bit(5, 1'b1, 3 * TC, n);
    fork
      high_len(5, n);
      begin
        ticks(1);
        conv_r.operation_ctrl <= 1'b0;
        ticks(1);
        conv_r.operation_ctrl <= 1'b1;
      end
    join
    chk(n, CLP * TC);
    wait_bit(3, 1'b1, 12 * TC, n);
    chk(drv.pulse_enable, 1'b1);
    @(posedge clk_sys);
    conv_r.contactor_ctrl <= 1'b1;
    wait_bit(4, 1'b1, 2 * TC, n);
    @(posedge clk_sys);
    conv_r.contactor_ctrl <= 1'b0;
    wait_bit(4, 1'b0, 2 * TC, n);
    apb(1'b1, IMASK_OFS, 32'h2);
    conv_r.fault_active <= 1'b1;
    wait_bit(6, 1'b0, 2 * TC, n);
    wait_bit(3, 1'b0, 12 * TC, n);
    chk(drv.pulse_enable, 1'b0);
    chk(irq, 1'b1);
    apb(1'b0, ISTAT_OFS, 0);
    chk(rv, 32'h6);
    apb(1'b1, ISTAT_OFS, 32'h6);
    apb(1'b0, ISTAT_OFS, 0);
    chk({irq, rv}, 33'h0);
    conv_r.fault_active <= 1'b0;
    conv_r.operation_ctrl <= 1'b0;
    wait_bit(6, 1'b1, 2 * TC, n);
    $display("test close and trip done");
  endtask : t_close_trip

  // Breaker stays open, so feedback comes from the substitute pulse only;
  // the close pulse runs meanwhile but its output is gated off
  task t_delay;
    int h;
    int hc;
    apb(1'b1, CTRL_OFS, 32'h0);
    conv_r.contactor_ctrl <= 1'b1;
    conv_r.operation_ctrl <= 1'b1;
    ticks(OND - 1);
    conv_r.contactor_ctrl <= 1'b0;
    apb(1'b0, STATUS_OFS, 0);
    chk(rv, 32'h40);
    h = 0;
    hc = 0;
    repeat (8 * TC) begin
      @(negedge clk_sys);
      h += drv.line_contactor_fb;
      hc += drv.breaker_close_do1;
    end
    chk(h, 0);
    chk(hc, 0);
    @(posedge clk_sys);
    conv_r.contactor_ctrl <= 1'b1;
    conv_r.operation_ctrl <= 1'b0;
    wait_bit(4, 1'b1, 10 * TC, n);
    h = (OND + 1) * TC;
    chk(n > h + 1 && n <= h + TC + 1, 1'b1);
    high_len(4, n);
    chk(n, FBP * TC);
    @(posedge clk_sys);
    conv_r.contactor_ctrl <= 1'b0;
    $display("test delay done");
  endtask : t_delay

  task t_monitor;
    int lo;
    apb(1'b1, CTRL_OFS, 32'h3);
    apb(1'b1, ISTAT_OFS, 32'h7);
    apb(1'b1, IMASK_OFS, 32'h1);
    conv_r.contactor_ctrl <= 1'b1;
    wait_bit(0, 1'b1, 50 * TC, n);
    lo = (OND + FBP + MON + 1) * TC;
    chk(n >= lo + 2 && n <= lo + 5, 1'b1);
    chk(irq, 1'b1);
    @(posedge clk_sys);
    conv_r.contactor_ctrl <= 1'b0;
    wait_bit(0, 1'b0, 3 * TC, n);
    apb(1'b1, ISTAT_OFS, 32'h1);
    @(negedge clk_sys);
    chk(irq, 1'b0);
    $display("test monitor done");
  endtask : t_monitor

  initial begin
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    t_regs;
    t_permit;
    t_close_trip;
    t_delay;
    t_monitor;
    report_and_stop;
  end
endmodule : tb
